// File: rtl/opp_pkg.sv
// Constants for the one-time-programmable memory programmer
package opp_pkg;

  // ****************************************
  // Address map and widths
  // ****************************************
  localparam int          ADDR_W        = 17;
  localparam int          DATA_W        = 8;
  localparam logic [16:0] ADDR_FIRST    = 17'h00000;
  localparam logic [16:0] ADDR_LAST     = 17'h0EFFF;
  localparam int          PAGE_BYTES    = 4;
  localparam int          MAX_TRIES     = 10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ        = 50000000;
  localparam int          PULSE_US      = 100;
  localparam int          PULSE_CYC     = (PULSE_US * (CLK_HZ / 1000000));
  localparam int          SETUP_NS      = 200;
  localparam int          SETUP_CYC     = (SETUP_NS + 19) / 20;

  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [1:0] {
    OPP_CMD_READ  = 2'h0,
    OPP_CMD_BYTE  = 2'h1,
    OPP_CMD_PAGE  = 2'h2
  } opp_cmd_t;

endpackage : opp_pkg

// File: rtl/opp_timer.sv
// Cycle timer used for strobe widths and setup delays
`timescale 1ns/100ps
module opp_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  // Status
  output logic              done
);

  logic [W-1:0] cnt_reg;
  logic         run_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= count;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= W'(1)) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - W'(1);
        end
      end
    end
  end

endmodule : opp_timer

// File: rtl/opp_prog.sv
// Pin-level programmer for a one-time-programmable program memory
`timescale 1ns/100ps
module opp_prog
  import opp_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int SETUP_CYCLES = SETUP_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // User command
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [31:0]       cmd_data,
  input  wire logic              cmd_hv,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [31:0]            rsp_data,
  output logic                   rsp_error,
  output logic [3:0]             rsp_tries,
  // Device pins
  output logic                   dev_reset_n,
  output logic                   vpp_high,
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   program_strobe_n,
  output logic [ADDR_W-1:0]      prog_addr_bus,
  output logic [DATA_W-1:0]      prog_data_bus_o,
  output logic                   prog_data_bus_oe,
  input  wire logic [DATA_W-1:0] prog_data_bus_i
);

  if (PULSE_CYCLES < 2 || PULSE_CYCLES > 65536 || SETUP_CYCLES < 1 || SETUP_CYCLES > 65533) begin : g_bad_timing
    $error("opp_prog: timing counts out of range");
  end

  // ****************************************
  // State machine
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SETUP   = 4'h1,
    ST_RD      = 4'h2,
    ST_LATCH   = 4'h3,
    ST_LATCH_E = 4'h4,
    ST_PULSE   = 4'h5,
    ST_RECOV   = 4'h6,
    ST_VFY     = 4'h7,
    ST_VFY_E   = 4'h8,
    ST_DONE    = 4'h9
  } opp_state_t;

  opp_state_t        st_reg;
  logic [1:0]        op_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [31:0]       wdata_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        idx_reg;
  logic [3:0]        tries_reg;
  logic              bad_reg;
  logic              tstart;
  logic [15:0]       tcount;
  logic              tdone;
  logic [DATA_W-1:0] din_s1_reg;
  logic [DATA_W-1:0] din_s2_reg;
  localparam logic [15:0] PULSE_CNT  = 16'(PULSE_CYCLES - 1);
  localparam logic [15:0] WIN_CNT    = 16'(SETUP_CYCLES);
  localparam logic [15:0] SAMPLE_CNT = 16'(SETUP_CYCLES + 2);

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] b, input logic [1:0] i);
    byte_addr = {b[ADDR_W-1:2], i};
  endfunction : byte_addr

  function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] i);
    lane = w[8*i +: 8];
  endfunction : lane

  // Pin input synchroniser
  always_ff @(posedge ref_clk) begin
    din_s1_reg <= prog_data_bus_i;
    din_s2_reg <= din_s1_reg;
  end

  opp_timer #(.W(16)) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (tstart),
    .count   (tcount),
    .done    (tdone)
  );

  // Next window length; sampling windows cover pin and synchroniser delay
  always_comb begin
    tstart = (st_reg == ST_IDLE) ? cmd_valid : tdone;
    case (st_reg)
      ST_SETUP: begin
        tcount = (op_reg == OPP_CMD_BYTE) ? PULSE_CNT : ((op_reg == OPP_CMD_PAGE) ? WIN_CNT : SAMPLE_CNT);
      end
      ST_LATCH_E: begin
        tcount = (idx_reg == 2'h3) ? PULSE_CNT : WIN_CNT;
      end
      ST_RECOV: begin
        tcount = SAMPLE_CNT;
      end
      ST_VFY_E: begin
        tcount = (op_reg == OPP_CMD_BYTE) ? PULSE_CNT : ((idx_reg != 2'h3) ? SAMPLE_CNT : WIN_CNT);
      end
      default: begin
        tcount = WIN_CNT;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg    <= ST_IDLE;
      op_reg    <= 2'h0;
      base_reg  <= '0;
      wdata_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      idx_reg   <= 2'h0;
      tries_reg <= 4'h0;
      bad_reg   <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 32'h00000000;
      rsp_error <= 1'b0;
      rsp_tries <= 4'h0;
      cmd_ready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      cmd_ready <= (st_reg == ST_IDLE) && !cmd_valid;
      case (st_reg)
        ST_IDLE: begin
          if (cmd_valid) begin
            op_reg    <= cmd_op;
            wdata_reg <= cmd_data;
            tries_reg <= 4'h1;
            bad_reg   <= 1'b0;
            base_reg  <= (cmd_op == OPP_CMD_PAGE) ? {cmd_addr[ADDR_W-1:2], 2'h0} : cmd_addr;
            idx_reg   <= (cmd_op == OPP_CMD_PAGE) ? 2'h0 : cmd_addr[1:0];
            st_reg    <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tdone) begin
            if (op_reg != OPP_CMD_READ && (base_reg > ADDR_LAST || cmd_hv == 1'b0)) begin
              bad_reg <= 1'b1;
              st_reg  <= ST_DONE;
            end else if (op_reg == OPP_CMD_BYTE) begin
              st_reg <= ST_PULSE;
            end else if (op_reg == OPP_CMD_PAGE) begin
              st_reg <= ST_LATCH;
            end else begin
              st_reg <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (tdone) begin
            rdata_reg <= {24'h000000, din_s2_reg};
            st_reg    <= ST_DONE;
          end
        end
        ST_LATCH, ST_PULSE: begin
          if (tdone) begin
            st_reg <= (st_reg == ST_LATCH) ? ST_LATCH_E : ST_RECOV;
          end
        end
        ST_LATCH_E: begin
          if (tdone) begin
            idx_reg <= idx_reg + 2'h1;
            st_reg  <= (idx_reg == 2'h3) ? ST_PULSE : ST_LATCH;
          end
        end
        ST_RECOV: begin
          if (tdone) begin
            idx_reg <= (op_reg == OPP_CMD_PAGE) ? 2'h0 : base_reg[1:0];
            bad_reg <= 1'b0;
            st_reg  <= ST_VFY;
          end
        end
        ST_VFY: begin
          if (tdone) begin
            bad_reg   <= bad_reg || (din_s2_reg != lane(wdata_reg, (op_reg == OPP_CMD_PAGE) ? idx_reg : 2'h0));
            rdata_reg <= {din_s2_reg, rdata_reg[31:8]};
            st_reg    <= ST_VFY_E;
          end
        end
        ST_VFY_E: begin
          if (tdone) begin
            if (op_reg == OPP_CMD_PAGE && idx_reg != 2'h3) begin
              idx_reg <= idx_reg + 2'h1;
              st_reg  <= ST_VFY;
            end else if (bad_reg && tries_reg < 4'(MAX_TRIES)) begin
              tries_reg <= tries_reg + 4'h1;
              idx_reg   <= (op_reg == OPP_CMD_PAGE) ? 2'h0 : base_reg[1:0];
              st_reg    <= (op_reg == OPP_CMD_PAGE) ? ST_LATCH : ST_PULSE;
            end else begin
              st_reg <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          rsp_valid <= 1'b1;
          rsp_data  <= (op_reg == OPP_CMD_BYTE) ? {24'h000000, rdata_reg[31:24]} : rdata_reg;
          rsp_error <= bad_reg;
          rsp_tries <= tries_reg;
          st_reg    <= ST_IDLE;
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dev_reset_n      <= 1'b1;
      vpp_high         <= 1'b0;
      chip_select_n    <= 1'b1;
      output_enable_n  <= 1'b1;
      program_strobe_n <= 1'b1;
      prog_addr_bus    <= '0;
      prog_data_bus_o  <= 8'h00;
      prog_data_bus_oe <= 1'b0;
    end else begin
      dev_reset_n      <= (st_reg == ST_IDLE && !cmd_valid);
      vpp_high         <= (st_reg != ST_IDLE) && (op_reg != OPP_CMD_READ);
      program_strobe_n <= 1'b1;
      prog_data_bus_oe <= 1'b0;
      chip_select_n    <= 1'b1;
      output_enable_n  <= 1'b1;
      prog_addr_bus    <= byte_addr(base_reg, idx_reg);
      prog_data_bus_o  <= lane(wdata_reg, (op_reg == OPP_CMD_PAGE) ? idx_reg : 2'h0);
      case (st_reg)
        ST_RD: begin
          chip_select_n   <= 1'b0;
          output_enable_n <= 1'b0;
        end
        ST_LATCH, ST_LATCH_E: begin
          output_enable_n  <= (st_reg == ST_LATCH_E);
          prog_data_bus_oe <= 1'b1;
        end
        ST_PULSE, ST_RECOV: begin
          chip_select_n    <= (op_reg == OPP_CMD_PAGE);
          program_strobe_n <= (st_reg == ST_RECOV);
          prog_data_bus_oe <= (op_reg == OPP_CMD_BYTE);
        end
        ST_VFY, ST_VFY_E: begin
          chip_select_n   <= (st_reg == ST_VFY_E) && (op_reg == OPP_CMD_PAGE);
          output_enable_n <= (st_reg == ST_VFY_E);
        end
        default: begin
          chip_select_n <= 1'b1;
        end
      endcase
    end
  end

endmodule : opp_prog

// File: verif/opp_prog_monitor.sv
// Assertion checker on the programmer ports
`timescale 1ns/100ps
module opp_prog_monitor
  import opp_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // Command side
  input wire logic              cmd_valid,
  input wire logic [1:0]        cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic              cmd_hv,
  input wire logic              cmd_ready,
  input wire logic              rsp_valid,
  input wire logic [3:0]        rsp_tries,
  // Device pins
  input wire logic              dev_reset_n,
  input wire logic              vpp_high,
  input wire logic              chip_select_n,
  input wire logic              output_enable_n,
  input wire logic              program_strobe_n,
  input wire logic [ADDR_W-1:0] prog_addr_bus,
  input wire logic              prog_data_bus_oe
);
  // ******
  // Checks
  // ******
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] low_cnt_reg;
  logic        wr_bad;
  assign wr_bad = cmd_op != 2'h0 && cmd_op != 2'h3 && (!cmd_hv || cmd_addr[16:2] > ADDR_LAST[16:2]);
  always_ff @(posedge ref_clk) begin
    low_cnt_reg <= (rst || program_strobe_n) ? 16'h0000 : low_cnt_reg + 16'h0001;
  end
  sequence pulse_end_s;
    $rose(program_strobe_n);
  endsequence
  sequence verify_s;
    !chip_select_n && !output_enable_n && program_strobe_n;
  endsequence
  chk_mode_entry: assert property ((!chip_select_n || !output_enable_n || !program_strobe_n) |-> !dev_reset_n)
    else $error("pins active with reset pin high");
  chk_pulse_supply: assert property (!program_strobe_n |-> vpp_high && output_enable_n)
    else $error("pulse without supply or with output enable low");
  chk_pulse_width: assert property (pulse_end_s |-> low_cnt_reg == 16'(PULSE_CYCLES))
    else $error("pulse width wrong");
  chk_verify_after: assert property (pulse_end_s |-> ##[1:60] verify_s)
    else $error("no verify after pulse");
  chk_no_contend: assert property (!chip_select_n && !output_enable_n |-> !prog_data_bus_oe)
    else $error("data driven while device outputs");
  chk_pulse_addr: assert property (!program_strobe_n |-> prog_addr_bus <= ADDR_LAST)
    else $error("pulse above last address");
  chk_refuse_wr: assert property (cmd_valid && cmd_ready && wr_bad |-> program_strobe_n [*8])
    else $error("refused write pulsed");
  chk_tries_cap: assert property (rsp_valid |-> rsp_tries >= 4'h1 && rsp_tries <= 4'hA)
    else $error("tries out of range");
endmodule : opp_prog_monitor

// File: verif/opp_dev_model.sv
// Behavioural model of the memory in programming mode
`timescale 1ns/100ps
module opp_dev_model #(
  parameter int PW = 20
) (
  // Pins from the programmer
  input wire logic        ref_clk,
  input wire logic        dev_reset_n,
  input wire logic        vpp_high,
  input wire logic        chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        program_strobe_n,
  input wire logic [16:0] prog_addr_bus,
  input wire logic [7:0]  prog_data_bus_i,
  // Device data
  output logic [7:0]      dev_data
);
  // ******
  // Memory
  // ******
  // array erased to ones
  logic [7:0]  mem [0:17'h0EFFF];
  logic [7:0]  lat_d [4];
  logic [14:0] lat_a;
  logic [7:0]  last = 8'h00;
  logic        drv;
  int          fails = 0;
  int          low_n = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  assign drv = !dev_reset_n && !chip_select_n && !output_enable_n && program_strobe_n;
  assign dev_data = drv ? mem[prog_addr_bus] : ~last;
  always @(posedge ref_clk) begin
    last <= dev_data;
    if (!dev_reset_n && vpp_high && chip_select_n && !output_enable_n && program_strobe_n) begin
      lat_d[prog_addr_bus[1:0]] <= prog_data_bus_i;
      lat_a <= prog_addr_bus[16:2];
    end
    low_n = program_strobe_n ? 0 : low_n + 1;
    if (low_n == PW && !dev_reset_n && vpp_high && output_enable_n) begin
      if (fails > 0) begin
        fails = fails - 1;
      end else if (chip_select_n) begin
        for (int i = 0; i < 4; i++) mem[{lat_a, 2'(i)}] &= lat_d[i];
      end else begin
        mem[prog_addr_bus] &= prog_data_bus_i;
      end
    end
  end
endmodule : opp_dev_model

// File: verif/tb.sv
// Self-checking bench for the programmer
`timescale 1ns/100ps
module tb;
  import opp_pkg::*;
  localparam int PW = 20;
  typedef struct packed {
    logic [1:0]  op;
    logic [16:0] a;
    logic [31:0] d;
    logic        hv;
    logic [31:0] x;
    logic        e;
    logic [3:0]  t;
  } opp_row_t;
  logic        ref_clk = 0, rst = 1, cmd_valid = 0, cmd_hv = 0;
  logic [1:0]  cmd_op = 0;
  logic [16:0] cmd_addr = 0, prog_addr_bus;
  logic [31:0] cmd_data = 0, rsp_data;
  logic        cmd_ready, rsp_valid, rsp_error, dev_reset_n, vpp_high, chip_select_n;
  logic        output_enable_n, program_strobe_n, prog_data_bus_oe;
  logic [3:0]  rsp_tries;
  logic [7:0]  prog_data_bus_o, prog_data_bus_i, dev_data;
  int          mismatches = 0, cmp_count = 0, cyc_cnt = 0;
  opp_row_t    rows [12] = '{
    '{2'h1, 17'h10, 32'h5A, 1'h1, 32'h5A, 1'h0, 4'h1}, '{2'h0, 17'h10, 32'h0, 1'h0, 32'h5A, 1'h0, 4'h0},
    '{2'h2, 17'h20, 32'h44332211, 1'h1, 32'h44332211, 1'h0, 4'h1},
    '{2'h0, 17'h22, 32'h0, 1'h0, 32'h33, 1'h0, 4'h0}, '{2'h0, 17'h21, 32'h0, 1'h0, 32'h22, 1'h0, 4'h0},
    '{2'h1, 17'hEFFF, 32'hC3, 1'h1, 32'hC3, 1'h0, 4'h1}, '{2'h0, 17'hEFFF, 32'h0, 1'h0, 32'hC3, 1'h0, 4'h0},
    '{2'h0, 17'h100, 32'h0, 1'h0, 32'hFF, 1'h0, 4'h0}, '{2'h1, 17'hF000, 32'hA5, 1'h1, 32'h0, 1'h1, 4'h1},
    '{2'h2, 17'hF000, 32'h0, 1'h1, 32'h0, 1'h1, 4'h1}, '{2'h1, 17'h30, 32'hA5, 1'h0, 32'h0, 1'h1, 4'h1},
    '{2'h0, 17'h30, 32'h0, 1'h0, 32'hFF, 1'h0, 4'h0}};
  assign prog_data_bus_i = prog_data_bus_oe ? prog_data_bus_o : dev_data;
  opp_prog #(.PULSE_CYCLES(PW), .SETUP_CYCLES(2)) uut (.*);
  opp_dev_model #(.PW(PW)) dev (.*);
  always #10 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task issue(input logic [1:0] op, input logic [16:0] a, input logic [31:0] d, input logic hv);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_hv <= hv;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
  endtask : issue
  task run(input logic [1:0] op, input logic [16:0] a, input logic [31:0] d, input logic hv);
    issue(op, a, d, hv);
    do @(negedge ref_clk); while (rsp_valid !== 1'b1);
  endtask : run
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 10000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d, rows[i].hv);
      chk("error", 32'(rsp_error), 32'(rows[i].e));
      if (!rows[i].e) chk("data", rows[i].op == 2'h2 ? rsp_data : 32'(rsp_data[7:0]), rows[i].x);
      if (rows[i].t != 4'h0) chk("tries", 32'(rsp_tries), 32'(rows[i].t));
    end
    dev.fails = 3;
    run(2'h1, 17'h40, 32'hA5, 1'h1);
    chk("retry", 32'(rsp_tries), 32'h4);
    dev.fails = 20;
    run(2'h1, 17'h44, 32'h3C, 1'h1);
    chk("cap", 32'(rsp_tries), 32'hA);
    chk("fail", 32'(rsp_error), 32'h1);
    dev.fails = 1;
    run(2'h2, 17'h50, 32'hA1B2C3D4, 1'h1);
    chk("page retry", rsp_data, 32'hA1B2C3D4);
    issue(2'h1, 17'h60, 32'h11, 1'h1);
    repeat (8) @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset pins", 32'({dev_reset_n, chip_select_n, program_strobe_n, prog_data_bus_oe}), 32'hE);
    @(posedge ref_clk);
    rst <= 1'h0;
    run(2'h0, 17'h60, 32'h0, 1'h0);
    chk("aborted", 32'(rsp_data[7:0]), 32'hFF);
    end_sim;
  end
endmodule : tb
bind opp_prog opp_prog_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) mon (.*);
